// ---- hafp_addr_filter.sv ----
/*
 * receive address filter: holds each byte one slot, decides on the address
 * bytes, then passes or drops the packet with a per-byte status code.
 * assumes input bytes arrive at least two cycles apart.
 */
module hafp_addr_filter
	import hafp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic enable,
	input wire logic [7:0] first_reg,
	input wire logic [7:0] second_reg,
	input wire logic seven_bit,
	input wire logic addr_recog,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_first,
	input wire logic in_last,
	input wire logic in_bad,
	output logic out_valid,
	output logic [7:0] out_data,
	output logic [1:0] out_code
);
	logic [7:0] first_byte_reg;
	logic [7:0] hold_reg;
	logic [1:0] hold_code_reg;
	logic hold_valid_reg;
	logic second_due_reg;
	logic accept_reg;
	logic flush_reg;

	function automatic logic first_hit(input logic [7:0] b, input logic [7:0] pat, input logic sev);
		first_hit = (b[7:2] == pat[7:2]) && (!sev || b[BIT_FIRST_EXTRA] == pat[BIT_FIRST_EXTRA]);
	endfunction

	wire a1_en = first_reg[BIT_MATCH_ENABLE];
	wire a2_en = second_reg[BIT_MATCH_ENABLE];
	wire [7:0] first_src = second_due_reg ? first_byte_reg : in_data;
	wire match1 = !a1_en || first_hit(first_src, first_reg, seven_bit);
	wire match2 = !a2_en || (in_data[7:1] == second_reg[7:1]);
	wire all_call = a1_en && a2_en && (first_src[7:1] == ALL_CALL);
	wire acc_single = !addr_recog || all_call || match1;
	wire acc_double = !addr_recog || all_call || (match1 && match2);
	wire [1:0] in_code = in_last ? (in_bad ? CODE_LAST_BAD : CODE_LAST_GOOD) :
		(in_first ? CODE_FIRST : CODE_PACKET);
	wire take = in_valid && enable;
	wire pass_now = second_due_reg ? acc_double : accept_reg;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			first_byte_reg <= REG_RESET;
			hold_reg <= REG_RESET;
			hold_code_reg <= CODE_PACKET;
			hold_valid_reg <= 1'b0;
			second_due_reg <= 1'b0;
			accept_reg <= 1'b0;
			flush_reg <= 1'b0;
			out_valid <= 1'b0;
			out_data <= REG_RESET;
			out_code <= CODE_PACKET;
		end else begin
			out_valid <= 1'b0;
			if (flush_reg) begin
				out_valid <= hold_valid_reg && accept_reg;
				out_data <= hold_reg;
				out_code <= hold_code_reg;
				hold_valid_reg <= 1'b0;
				flush_reg <= 1'b0;
			end else if (take && in_first) begin
				first_byte_reg <= in_data;
				hold_reg <= in_data;
				hold_code_reg <= in_code;
				hold_valid_reg <= 1'b1;
				second_due_reg <= !in_last;
				accept_reg <= in_last && acc_single;
				flush_reg <= in_last;
			end else if (take && hold_valid_reg) begin
				out_valid <= pass_now;
				out_data <= hold_reg;
				out_code <= hold_code_reg;
				accept_reg <= pass_now;
				second_due_reg <= 1'b0;
				hold_reg <= in_data;
				hold_code_reg <= in_code;
				flush_reg <= in_last;
			end
		end
	end
endmodule

// ---- hafp_link_model.sv ----
/*
 * far side of both channels: hands whole received bytes with packet
 * markers, pulses go-ahead, and takes tagged transmit entries.
 * assumes the bench sets stall and slow and calls send and pulse_go_ahead.
 */
module hafp_link_model (
	input wire logic clk_sys,
	output logic [1:0] rx_valid,
	output logic [1:0][7:0] rx_data,
	output logic [1:0] rx_first,
	output logic [1:0] rx_last,
	output logic [1:0] rx_bad,
	output logic [1:0] rx_idle,
	output logic [1:0] rx_go_ahead,
	output logic [1:0][15:0] rx_check,
	input wire logic [1:0] tx_valid,
	input wire logic [1:0][9:0] tx_data,
	output logic [1:0] tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic [9:0] got0 [$];
	logic [9:0] got1 [$];

	initial begin
		rx_valid = '0;
		rx_data = '0;
		rx_first = '0;
		rx_last = '0;
		rx_bad = '0;
		rx_idle = 2'b11;
		rx_go_ahead = '0;
		rx_check = {16'h5AC3, 16'hA53C};
		tx_ready = '0;
	end

	// slow mode offers ready every other cycle
	always @(posedge clk_sys) begin
		if (tx_valid[0] && tx_ready[0])
			got0.push_back(tx_data[0]);
		if (tx_valid[1] && tx_ready[1])
			got1.push_back(tx_data[1]);
		tx_ready <= stall ? 2'b00 : slow ? ~tx_ready : 2'b11;
	end

	// released data line shows the inverse of the last byte
	task automatic send(input int ch, input logic [7:0] d, input logic f, input logic l, input logic b);
		@(posedge clk_sys);
		rx_valid[ch] <= 1'b1;
		rx_data[ch] <= d;
		rx_first[ch] <= f;
		rx_last[ch] <= l;
		rx_bad[ch] <= b;
		rx_idle[ch] <= 1'b0;
		@(posedge clk_sys);
		rx_valid[ch] <= 1'b0;
		rx_data[ch] <= ~d;
		rx_first[ch] <= 1'b0;
		rx_last[ch] <= 1'b0;
		rx_bad[ch] <= 1'b0;
		rx_idle[ch] <= l;
		@(posedge clk_sys);
	endtask

	task automatic pulse_go_ahead(input int ch);
		@(posedge clk_sys);
		rx_go_ahead[ch] <= 1'b1;
		@(posedge clk_sys);
		rx_go_ahead[ch] <= 1'b0;
	endtask
endmodule

// ---- hafp_pkg.sv ----
/*
 * constants shared by the two-channel hdlc address filter and fifo port:
 * pages, register offsets, field positions and sizes.
 * assumes an 8-bit paged register port and a byte-wide link on each side.
 */
package hafp_pkg;

	// ************
	// pages and offsets
	// ************
	localparam int HAFP_CHANNELS = 2;
	localparam logic [7:0] PAGE_CH0 = 8'h0B;
	localparam logic [7:0] PAGE_CH1 = 8'h0C;
	localparam logic [7:0] OFS_FIRST_ADDR = 8'h10;
	localparam logic [7:0] OFS_SECOND_ADDR = 8'h11;
	localparam logic [7:0] OFS_QUEUE_PORT = 8'h12;
	localparam logic [7:0] OFS_CONTROL_ONE = 8'h13;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CONTROL_TWO = 8'h15;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h16;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h17;
	localparam logic [7:0] OFS_CHECK_HIGH = 8'h18;
	localparam logic [7:0] OFS_CHECK_LOW = 8'h19;
	localparam logic [7:0] OFS_TX_LENGTH = 8'h1A;
	localparam logic [7:0] OFS_TEST_CONTROL = 8'h1B;
	localparam logic [7:0] OFS_TEST_STATUS = 8'h1C;
	localparam logic [7:0] OFS_CONTROL_THREE = 8'h1D;
	localparam logic [7:0] OFS_CONTROL_FOUR = 8'h1E;

	// ************
	// field positions
	// ************
	localparam int BIT_MATCH_ENABLE = 0;
	localparam int BIT_FIRST_EXTRA = 1;
	localparam int BIT_ADDR_RECOG = 7;
	localparam int BIT_RX_ENABLE = 6;
	localparam int BIT_TX_ENABLE = 5;
	localparam int BIT_END_TAG = 4;
	localparam int BIT_ABORT_TAG = 3;
	localparam int BIT_MARK_IDLE = 2;
	localparam int BIT_SEVEN_BIT = 4;
	localparam int BIT_RX_FLUSH = 1;
	localparam int BIT_TX_FLUSH = 0;

	// event flag bits
	localparam int EV_GO_AHEAD = 7;
	localparam int EV_END_DETECTED = 6;
	localparam int EV_TX_END_SENT = 5;
	localparam int EV_END_RECEIVED = 4;
	localparam int EV_TX_LOW = 3;
	localparam int EV_TX_UNDERRUN = 2;
	localparam int EV_RX_FULL = 1;
	localparam int EV_RX_OVERFLOW = 0;

	// ************
	// codes and sizes
	// ************
	localparam logic [1:0] CODE_PACKET = 2'h0;
	localparam logic [1:0] CODE_FIRST = 2'h1;
	localparam logic [1:0] CODE_LAST_GOOD = 2'h2;
	localparam logic [1:0] CODE_LAST_BAD = 2'h3;
	localparam logic [6:0] ALL_CALL = 7'h7F;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int QUEUE_DEPTH = 16;
	localparam int TX_ENTRY_W = 10;
	localparam int RX_ENTRY_W = 10;

endpackage

// ---- hafp_queue.sv ----
/*
 * synchronous fifo with flags that lag the pointers by one cycle.
 * assumes nothing of the caller: push and pop are guarded here with the true level.
 */
module hafp_queue #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic flush,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic [$clog2(DEPTH):0] level,
	output logic empty_flag,
	output logic full_flag
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] level_reg;
	wire do_push = push && (level_reg != DEPTH_L);
	wire do_pop = pop && (level_reg != '0);

	assign head = mem[rd_ptr_reg];
	assign level = level_reg;

	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[wr_ptr_reg] <= push_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
			rd_ptr_reg <= rd_ptr_reg + AW'(do_pop);
			level_reg <= level_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// flags follow the settled level one cycle later
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			empty_flag <= 1'b1;
			full_flag <= 1'b0;
		end else begin
			empty_flag <= (level_reg == '0);
			full_flag <= (level_reg == DEPTH_L);
		end
	end
endmodule

// ---- hafp_top.sv ----
/*
 * two hdlc register sets behind a paged byte register port: address
 * recognition, tagged transmit queue writes, receive queue reads with
 * per-byte status, event flags with mask and one interrupt output.
 * assumes the serial framing logic hands over whole bytes with packet
 * markers and takes tagged transmit bytes with valid/ready.
 */
module hafp_top
	import hafp_pkg::*;
#(
	parameter int DEPTH = hafp_pkg::QUEUE_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	input wire logic [1:0] rx_valid,
	input wire logic [1:0][7:0] rx_data,
	input wire logic [1:0] rx_first,
	input wire logic [1:0] rx_last,
	input wire logic [1:0] rx_bad,
	input wire logic [1:0] rx_idle,
	input wire logic [1:0] rx_go_ahead,
	input wire logic [1:0] rx_end_seen,
	input wire logic [1:0][15:0] rx_check,
	input wire logic [1:0] tx_underrun,
	output logic [1:0] tx_valid,
	output logic [1:0][9:0] tx_data,
	input wire logic [1:0] tx_ready,
	output logic [1:0] rx_enable,
	output logic [1:0] tx_enable,
	output logic [1:0] mark_idle
);
	import hafp_pkg::*;

	localparam int LW = $clog2(DEPTH) + 1;

	// ************
	// register storage
	// ************
	logic [1:0][7:0] first_addr_reg;
	logic [1:0][7:0] second_addr_reg;
	logic [1:0][7:0] ctl_one_reg;
	logic [1:0][7:0] ctl_two_reg;
	logic [1:0][7:0] mask_reg;
	logic [1:0][7:0] flags_reg;
	logic [1:0][7:0] tx_len_reg;
	logic [1:0][7:0] test_ctl_reg;
	logic [1:0][7:0] ctl_three_reg;
	logic [1:0][7:0] ctl_four_reg;
	logic [1:0][1:0] rx_code_reg;
	logic [1:0] rx_full_d_reg;
	logic [1:0] tx_empty_d_reg;

	// ************
	// address decode
	// ************
	function automatic logic [1:0] page_hit(input logic [7:0] page);
		page_hit = {page == PAGE_CH1, page == PAGE_CH0};
	endfunction

	wire [1:0] sel = page_hit(reg_page);
	wire ch = sel[1];
	wire any_sel = |sel;
	wire wr_hit = reg_wr && any_sel;
	wire rd_hit = reg_rd && any_sel;
	wire wr_first = wr_hit && reg_addr == OFS_FIRST_ADDR;
	wire wr_second = wr_hit && reg_addr == OFS_SECOND_ADDR;
	wire wr_queue = wr_hit && reg_addr == OFS_QUEUE_PORT;
	wire wr_ctl_one = wr_hit && reg_addr == OFS_CONTROL_ONE;
	wire wr_ctl_two = wr_hit && reg_addr == OFS_CONTROL_TWO;
	wire wr_mask = wr_hit && reg_addr == OFS_EVENT_MASK;
	wire wr_len = wr_hit && reg_addr == OFS_TX_LENGTH;
	wire wr_test = wr_hit && reg_addr == OFS_TEST_CONTROL;
	wire wr_ctl_three = wr_hit && reg_addr == OFS_CONTROL_THREE;
	wire wr_ctl_four = wr_hit && reg_addr == OFS_CONTROL_FOUR;
	wire rd_queue = rd_hit && reg_addr == OFS_QUEUE_PORT;
	wire rd_flags = rd_hit && reg_addr == OFS_EVENT_FLAGS;

	// ************
	// queues and filters per channel
	// ************
	logic [1:0] tx_push;
	logic [1:0] tx_pop;
	logic [1:0] rx_pop;
	logic [1:0][9:0] tx_head;
	logic [1:0][9:0] rx_head;
	logic [1:0][LW-1:0] tx_level;
	logic [1:0][LW-1:0] rx_level;
	logic [1:0] tx_empty;
	logic [1:0] tx_full;
	logic [1:0] rx_empty;
	logic [1:0] rx_full;
	logic [1:0] f_valid;
	logic [1:0][7:0] f_data;
	logic [1:0][1:0] f_code;
	logic [1:0] rx_push;
	logic [1:0] rx_over;
	logic [1:0] tx_handed;

	genvar g;
	generate
		for (g = 0; g < HAFP_CHANNELS; g++) begin : g_ch
			wire [9:0] tx_entry = {ctl_one_reg[g][BIT_END_TAG], ctl_one_reg[g][BIT_ABORT_TAG], reg_wdata};
			assign tx_push[g] = wr_queue && (ch == 1'(g));
			assign rx_pop[g] = rd_queue && (ch == 1'(g)) && (rx_level[g] != '0);
			assign tx_handed[g] = tx_valid[g] && tx_ready[g];
			assign tx_pop[g] = (tx_level[g] != '0) && (!tx_valid[g] || tx_ready[g]);
			assign rx_push[g] = f_valid[g] && !rx_over[g];
			assign rx_over[g] = f_valid[g] && (rx_level[g] == LW'(DEPTH));

			hafp_queue #(.WIDTH(TX_ENTRY_W), .DEPTH(DEPTH)) u_tx_queue (
				.clk_sys(clk_sys),
				.reset(reset),
				.flush(ctl_two_reg[g][BIT_TX_FLUSH]),
				.push(tx_push[g]),
				.push_data(tx_entry),
				.pop(tx_pop[g]),
				.head(tx_head[g]),
				.level(tx_level[g]),
				.empty_flag(tx_empty[g]),
				.full_flag(tx_full[g])
			);

			hafp_queue #(.WIDTH(RX_ENTRY_W), .DEPTH(DEPTH)) u_rx_queue (
				.clk_sys(clk_sys),
				.reset(reset),
				.flush(ctl_two_reg[g][BIT_RX_FLUSH]),
				.push(rx_push[g]),
				.push_data({f_code[g], f_data[g]}),
				.pop(rx_pop[g]),
				.head(rx_head[g]),
				.level(rx_level[g]),
				.empty_flag(rx_empty[g]),
				.full_flag(rx_full[g])
			);

			hafp_addr_filter u_filter (
				.clk_sys(clk_sys),
				.reset(reset),
				.enable(ctl_one_reg[g][BIT_RX_ENABLE]),
				.first_reg(first_addr_reg[g]),
				.second_reg(second_addr_reg[g]),
				.seven_bit(ctl_two_reg[g][BIT_SEVEN_BIT]),
				.addr_recog(ctl_one_reg[g][BIT_ADDR_RECOG]),
				.in_valid(rx_valid[g]),
				.in_data(rx_data[g]),
				.in_first(rx_first[g]),
				.in_last(rx_last[g]),
				.in_bad(rx_bad[g]),
				.out_valid(f_valid[g]),
				.out_data(f_data[g]),
				.out_code(f_code[g])
			);
		end
	endgenerate

	// ************
	// events
	// ************
	logic [1:0][7:0] events;
	logic [1:0][7:0] irq_src;
	always_comb begin
		for (int c = 0; c < HAFP_CHANNELS; c++) begin
			events[c] = '0;
			events[c][EV_GO_AHEAD] = rx_go_ahead[c];
			events[c][EV_END_DETECTED] = rx_end_seen[c];
			events[c][EV_TX_END_SENT] = tx_handed[c] && tx_data[c][9];
			events[c][EV_END_RECEIVED] = rx_push[c] && f_code[c][1];
			events[c][EV_TX_LOW] = tx_empty[c] && !tx_empty_d_reg[c];
			events[c][EV_TX_UNDERRUN] = tx_underrun[c];
			events[c][EV_RX_FULL] = rx_full[c] && !rx_full_d_reg[c];
			events[c][EV_RX_OVERFLOW] = rx_over[c];
			irq_src[c] = flags_reg[c] & mask_reg[c];
		end
	end

	// ************
	// read mux
	// ************
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			OFS_FIRST_ADDR: rd_mux = first_addr_reg[ch];
			OFS_SECOND_ADDR: rd_mux = second_addr_reg[ch];
			OFS_QUEUE_PORT: rd_mux = (rx_level[ch] != '0) ? rx_head[ch][7:0] : REG_RESET;
			OFS_CONTROL_ONE: rd_mux = ctl_one_reg[ch];
			OFS_STATUS: rd_mux = {|irq_src[ch], rx_idle[ch], rx_code_reg[ch],
				tx_full[ch], tx_empty[ch], rx_full[ch], rx_empty[ch]};
			OFS_CONTROL_TWO: rd_mux = ctl_two_reg[ch];
			OFS_EVENT_MASK: rd_mux = mask_reg[ch];
			OFS_EVENT_FLAGS: rd_mux = flags_reg[ch];
			OFS_CHECK_HIGH: rd_mux = rx_check[ch][15:8];
			OFS_CHECK_LOW: rd_mux = rx_check[ch][7:0];
			OFS_TX_LENGTH: rd_mux = tx_len_reg[ch];
			OFS_TEST_CONTROL: rd_mux = test_ctl_reg[ch];
			OFS_CONTROL_THREE: rd_mux = ctl_three_reg[ch];
			OFS_CONTROL_FOUR: rd_mux = ctl_four_reg[ch];
			default: rd_mux = REG_RESET;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reg_rdata <= REG_RESET;
		end else if (reg_rd) begin
			reg_rdata <= any_sel ? rd_mux : REG_RESET;
		end
	end

	// ************
	// register writes
	// ************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			first_addr_reg <= '0;
			second_addr_reg <= '0;
			ctl_one_reg <= '0;
			ctl_two_reg <= '0;
			mask_reg <= '0;
			tx_len_reg <= '0;
			test_ctl_reg <= '0;
			ctl_three_reg <= '0;
			ctl_four_reg <= '0;
		end else begin
			for (int c = 0; c < HAFP_CHANNELS; c++) begin
				if (sel[c]) begin
					if (wr_first) first_addr_reg[c] <= reg_wdata;
					if (wr_second) second_addr_reg[c] <= reg_wdata;
					if (wr_ctl_one) ctl_one_reg[c] <= reg_wdata;
					if (wr_ctl_two) ctl_two_reg[c] <= reg_wdata;
					if (wr_mask) mask_reg[c] <= reg_wdata;
					if (wr_len) tx_len_reg[c] <= reg_wdata;
					if (wr_test) test_ctl_reg[c] <= reg_wdata;
					if (wr_ctl_three) ctl_three_reg[c] <= reg_wdata;
					if (wr_ctl_four) ctl_four_reg[c] <= reg_wdata;
				end
				if (tx_push[c]) begin
					ctl_one_reg[c][BIT_END_TAG] <= 1'b0;
					ctl_one_reg[c][BIT_ABORT_TAG] <= 1'b0;
				end
				// queue flush bits act for one cycle
				if (ctl_two_reg[c][BIT_RX_FLUSH]) ctl_two_reg[c][BIT_RX_FLUSH] <= 1'b0;
				if (ctl_two_reg[c][BIT_TX_FLUSH]) ctl_two_reg[c][BIT_TX_FLUSH] <= 1'b0;
			end
		end
	end

	// ************
	// flags, popped status, interrupt
	// ************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flags_reg <= '0;
			rx_code_reg <= '0;
			rx_full_d_reg <= '0;
			tx_empty_d_reg <= '1;
			irq <= 1'b0;
		end else begin
			for (int c = 0; c < HAFP_CHANNELS; c++) begin
				// a new event wins over the read that clears
				flags_reg[c] <= ((rd_flags && sel[c]) ? 8'h00 : flags_reg[c]) | events[c];
				if (rx_pop[c]) rx_code_reg[c] <= rx_head[c][9:8];
				rx_full_d_reg[c] <= rx_full[c];
				tx_empty_d_reg[c] <= tx_empty[c];
			end
			irq <= |irq_src;
		end
	end

	// ************
	// link side outputs
	// ************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_valid <= '0;
			tx_data <= '0;
			rx_enable <= '0;
			tx_enable <= '0;
			mark_idle <= '0;
		end else begin
			for (int c = 0; c < HAFP_CHANNELS; c++) begin
				if (tx_pop[c]) begin
					tx_valid[c] <= 1'b1;
					tx_data[c] <= tx_head[c];
				end else if (tx_ready[c]) begin
					tx_valid[c] <= 1'b0;
				end
				rx_enable[c] <= ctl_one_reg[c][BIT_RX_ENABLE];
				tx_enable[c] <= ctl_one_reg[c][BIT_TX_ENABLE];
				mark_idle[c] <= ctl_one_reg[c][BIT_MARK_IDLE];
			end
		end
	end
endmodule

// ---- hafp_top_sva.sv ----
/*
 * checker for hafp_top: register port answers, transmit link hand-over,
 * transmit tags and control copies on channel 0, transmit on channel 1.
 * assumes it is bound to hafp_top and sees only its ports.
 */
module hafp_top_chk
	import hafp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq,
	input wire logic [1:0] tx_valid,
	input wire logic [1:0][9:0] tx_data,
	input wire logic [1:0] tx_ready,
	input wire logic [1:0] rx_enable,
	input wire logic [1:0] tx_enable
);
	// ************
	// decodes
	// ************
	wire logic wr0 = reg_wr && reg_page == PAGE_CH0;
	wire logic rd0 = reg_rd && reg_page == PAGE_CH0;
	wire logic wr1 = reg_wr && reg_page == PAGE_CH1;
	wire logic mapped = reg_page == PAGE_CH0 || reg_page == PAGE_CH1;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// ************
	// assertions
	// ************
	chk_rdata_hold: assert property (!$past(reg_rd) && !$past(reset) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped page read not zero");
	chk_reset_quiet: assert property ($past(reset) |-> reg_rdata == 8'h00 && !irq && tx_valid == 2'b00)
		else $error("outputs not idle after reset");
	chk_tx_hold: assert property (tx_valid[0] && !tx_ready[0] |=> tx_valid[0] && $stable(tx_data[0]))
		else $error("transmit entry dropped while stalled");
	// entry lands at the write edge, is popped one edge later, seen at the third
	chk_tx_write: assert property (wr0 && reg_addr == OFS_QUEUE_PORT && !tx_valid[0]
		&& !$past(wr0 && reg_addr == OFS_QUEUE_PORT)
		|-> ##2 tx_valid[0] && tx_data[0][7:0] == $past(reg_wdata, 2))
		else $error("written byte not offered on channel 0");
	chk_tx_write_one: assert property (wr1 && reg_addr == OFS_QUEUE_PORT && !tx_valid[1]
		&& !$past(wr1 && reg_addr == OFS_QUEUE_PORT)
		|-> ##2 tx_valid[1] && tx_data[1][7:0] == $past(reg_wdata, 2))
		else $error("written byte not offered on channel 1");
	chk_end_tag_mark: assert property (wr0 && reg_addr == OFS_CONTROL_ONE && reg_wdata[4]
		##1 wr0 && reg_addr == OFS_QUEUE_PORT && !tx_valid[0] |-> ##2 tx_data[0][9])
		else $error("end tag missing on entry");
	chk_tag_self_clear: assert property (wr0 && reg_addr == OFS_QUEUE_PORT
		##1 rd0 && reg_addr == OFS_CONTROL_ONE |=> reg_rdata[4:3] == 2'b00)
		else $error("tags still set after queue write");
	chk_flag_lag: assert property (wr0 && reg_addr == OFS_QUEUE_PORT && !tx_valid[0] && !$past(tx_valid[0])
		##1 rd0 && reg_addr == OFS_STATUS |=> reg_rdata[2])
		else $error("empty flag changed with the write");
	chk_ctrl_copy: assert property (wr0 && reg_addr == OFS_CONTROL_ONE
		|-> ##2 rx_enable[0] == $past(reg_wdata[6], 2) && tx_enable[0] == $past(reg_wdata[5], 2))
		else $error("enable copies wrong");

	cover_rx_pop: cover property (rd0 && reg_addr == OFS_QUEUE_PORT);
	cover_irq_rise: cover property ($rose(irq));
	cover_tx_take: cover property (tx_valid[0] && tx_ready[0]);
endmodule

bind hafp_top hafp_top_chk u_chk (.clk_sys(clk_sys), .reset(reset), .reg_page(reg_page), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_enable(rx_enable), .tx_enable(tx_enable));

// ---- hafp_top_tb.sv ----
/*
 * self-checking bench for hafp_top: registers, address filter, transmit
 * tags and queue flags, event flags and interrupt.
 * assumes hafp_link_model on the link side and a queue depth of 4.
 */
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module hafp_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hafp_pkg::*;
	logic clk_sys, reset, reg_wr, reg_rd, irq;
	logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata;
	logic [1:0] rx_valid, rx_first, rx_last, rx_bad, rx_idle, rx_go_ahead, tx_valid, tx_ready;
	logic [1:0] rx_enable, tx_enable, mark_idle;
	logic [1:0][7:0] rx_data;
	logic [1:0][15:0] rx_check;
	logic [1:0][9:0] tx_data;
	int mismatches = 0;
	int n_compared = 0;

	hafp_top #(.DEPTH(4)) uut (.clk_sys(clk_sys), .reset(reset), .reg_page(reg_page), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last), .rx_bad(rx_bad),
		.rx_idle(rx_idle), .rx_go_ahead(rx_go_ahead), .rx_end_seen(2'b00), .rx_check(rx_check),
		.tx_underrun(2'b00), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_enable(rx_enable), .tx_enable(tx_enable), .mark_idle(mark_idle));
	hafp_link_model lm (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first),
		.rx_last(rx_last), .rx_bad(rx_bad), .rx_idle(rx_idle), .rx_go_ahead(rx_go_ahead), .rx_check(rx_check),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ************
	// register port
	// ************
	task automatic drive(input logic w, input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= !w;
		reg_page <= p;
		reg_addr <= a;
		reg_wdata <= d;
	endtask

	task automatic bus(input logic w, input logic [7:0] p, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		drive(w, p, a, d);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask

	task automatic bus2(input logic w1, input logic [7:0] a1, input logic [7:0] d1,
		input logic w2, input logic [7:0] a2, input logic [7:0] d2, output logic [7:0] q1, output logic [7:0] q2);
		drive(w1, PAGE_CH0, a1, d1);
		drive(w2, PAGE_CH0, a2, d2);
		#1 q1 = reg_rdata;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 q2 = reg_rdata;
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ************
	// scenarios
	// ************
	task automatic reg_paths();
		logic [7:0] q;
		bus(0, PAGE_CH0, OFS_FIRST_ADDR, 8'h00, q);
		`CHK(q, REG_RESET)
		bus(1, PAGE_CH0, OFS_FIRST_ADDR, 8'hC5, q);
		bus(1, PAGE_CH1, OFS_FIRST_ADDR, 8'h3A, q);
		bus(1, PAGE_CH1, OFS_SECOND_ADDR, 8'hB3, q);
		bus(1, 8'h0D, OFS_FIRST_ADDR, 8'hFF, q);
		bus(0, PAGE_CH0, OFS_FIRST_ADDR, 8'h00, q);
		`CHK(q, 8'hC5)
		bus(0, PAGE_CH1, OFS_FIRST_ADDR, 8'h00, q);
		`CHK(q, 8'h3A)
		bus(0, PAGE_CH1, OFS_SECOND_ADDR, 8'h00, q);
		`CHK(q, 8'hB3)
		bus(0, 8'h0D, OFS_FIRST_ADDR, 8'h00, q);
		`CHK(q, 8'h00)
	endtask

	// rows: first, second, control two, byte one, byte two, {recog, bad, accept}
	task automatic filter_cases();
		logic [47:0] t [10] = '{48'hA9_55_00_AB_54_81, 48'hA9_55_10_AB_54_80, 48'hA9_55_00_6B_54_80,
			48'hA8_55_00_6B_54_81, 48'hA9_55_00_AB_56_80, 48'hA9_54_00_AB_56_81, 48'hA9_55_00_FE_00_81,
			48'hA9_54_00_FE_00_80, 48'hA8_55_00_FE_00_80, 48'hA9_55_00_6B_00_03};
		logic [7:0] q1, q2;
		for (int i = 0; i < 10; i++) begin
			bus(1, PAGE_CH0, OFS_CONTROL_ONE, 8'h40, q1);
			bus(1, PAGE_CH0, OFS_FIRST_ADDR, t[i][47:40], q1);
			bus(1, PAGE_CH0, OFS_SECOND_ADDR, t[i][39:32], q1);
			bus(1, PAGE_CH0, OFS_CONTROL_TWO, t[i][31:24], q1);
			bus(1, PAGE_CH0, OFS_CONTROL_ONE, t[i][7] ? 8'hC0 : 8'h40, q1);
			lm.send(0, t[i][23:16], 1'b1, 1'b0, 1'b0);
			lm.send(0, t[i][15:8], 1'b0, 1'b0, 1'b0);
			lm.send(0, 8'h5A, 1'b0, 1'b1, t[i][1]);
			repeat (4) @(posedge clk_sys);
			for (int j = 0; j < 3; j++) begin
				bus2(0, OFS_QUEUE_PORT, 8'h00, 0, OFS_STATUS, 8'h00, q1, q2);
				if (t[i][0]) begin
					`CHK(q1, j == 0 ? t[i][23:16] : j == 1 ? t[i][15:8] : 8'h5A)
					`CHK(q2[5:4], j == 0 ? CODE_FIRST : j == 1 ? CODE_PACKET : t[i][1] ? CODE_LAST_BAD : CODE_LAST_GOOD)
					if (j == 2)
						`CHK(q2[0], 1'b0)
				end else begin
					`CHK(q2[0], 1'b1)
				end
			end
		end
	endtask

	task automatic tx_tags();
		logic [7:0] q1, q2;
		lm.stall = 1'b1;
		bus2(1, OFS_CONTROL_ONE, 8'h38, 1, OFS_QUEUE_PORT, 8'h3C, q1, q2);
		bus2(1, OFS_QUEUE_PORT, 8'h77, 0, OFS_CONTROL_ONE, 8'h00, q1, q2);
		`CHK(q2[4:3], 2'b00)
		bus(1, PAGE_CH1, OFS_QUEUE_PORT, 8'h99, q1);
		bus(0, PAGE_CH0, OFS_STATUS, 8'h00, q1);
		`CHK(q1[2], 1'b0)
		lm.slow = 1'b1;
		lm.stall = 1'b0;
		repeat (12) @(posedge clk_sys);
		bus2(1, OFS_QUEUE_PORT, 8'h11, 0, OFS_STATUS, 8'h00, q1, q2);
		`CHK(q2[2], 1'b1)
		repeat (8) @(posedge clk_sys);
		`CHK(lm.got0.size(), 3)
		`CHK(lm.got0[0], {2'b11, 8'h3C})
		`CHK(lm.got0[1], {2'b00, 8'h77})
		`CHK(lm.got0[2], {2'b00, 8'h11})
		`CHK(lm.got1[0], {2'b00, 8'h99})
	endtask

	task automatic irq_cycle();
		logic [7:0] q;
		bus(0, PAGE_CH0, OFS_EVENT_FLAGS, 8'h00, q);
		bus(0, PAGE_CH1, OFS_EVENT_FLAGS, 8'h00, q);
		lm.pulse_go_ahead(0);
		repeat (2) @(posedge clk_sys);
		#1 `CHK(irq, 1'b0)
		bus(1, PAGE_CH0, OFS_EVENT_MASK, 8'h80, q);
		repeat (2) @(posedge clk_sys);
		#1 `CHK(irq, 1'b1)
		bus(0, PAGE_CH0, OFS_EVENT_FLAGS, 8'h00, q);
		`CHK(q, 8'h80)
		repeat (2) @(posedge clk_sys);
		#1 `CHK(irq, 1'b0)
	endtask

	// ************
	// sequence and watchdog
	// ************
	initial begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_page = 8'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		reg_paths();
		filter_cases();
		tx_tags();
		irq_cycle();
		conclude();
	end

	initial begin
		#(50 * 30000);
		mismatches++;
		conclude();
	end
endmodule
